// ---- adc_regs_pkg.sv ----
package adc_regs_pkg;

   // Register indices on the register port
   localparam logic [2:0] ADDR_RESULT_LOW  = 3'h0;
   localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
   localparam logic [2:0] ADDR_LIMIT_FLAGS = 3'h2;
   localparam logic [2:0] ADDR_CONTROL     = 3'h3;
   localparam logic [2:0] ADDR_GAIN_CHAN   = 3'h4;

   // Field positions
   localparam int CTRL_BINARY_BIT = 5;
   localparam int CTRL_RBM_HI     = 3;
   localparam int CTRL_RBM_LO     = 2;
   localparam int CTRL_CFD_HI     = 1;
   localparam int CTRL_CFD_LO     = 0;
   localparam int GC_BUSY_BIT     = 7;
   localparam int GC_GAIN_HI      = 6;
   localparam int GC_GAIN_LO      = 4;
   localparam int GC_CHAN_HI      = 3;
   localparam int GC_CHAN_LO      = 0;
   localparam int CHAN_SINGLE_BIT = 3;
   localparam int CHAN_SWAP_BIT   = 2;
   localparam int RESULT_MSB      = 13;

   // Reset values
   localparam logic [7:0]  BYTE_RESET   = 8'h00;
   localparam logic [13:0] RESULT_RESET = 14'h0000;
   localparam logic [5:0]  LIMIT_RESET  = 6'h00;

   // Read-back modes
   localparam logic [1:0] RBM_EXPLICIT  = 2'h0;
   localparam logic [1:0] RBM_HIGH_1ST  = 2'h1;
   localparam logic [1:0] RBM_LOW_1ST   = 2'h2;
   localparam logic [1:0] RBM_HIGH_ONLY = 2'h3;

   // Divided clock falling edges from start request to conversion start
   localparam logic [1:0] START_FALLS = 2'h2;

   // Automatic read-back word handed to the serial side
   typedef struct packed {
      logic       valid;       // One-cycle pulse
      logic       twoBytes;    // Second byte follows
      logic [7:0] firstByte;   // Byte shifted out first
      logic [7:0] secondByte;  // Byte shifted out second
   } readback_t;

   // Conversion setup presented to the analog side
   typedef struct packed {
      logic [2:0] gainCode;    // Amplifier gain code
      logic [4:0] gainFactor;  // Decoded gain in V/V
      logic [7:0] plusSel;     // One-hot plus input select
      logic [7:0] minusSel;    // One-hot minus select, zero is ground
   } conv_setup_t;

endpackage : adc_regs_pkg

// ---- adc_result_and_control_regs.sv ----
// Function
// R1 - Low byte upper six: result bits five-zero
// R2 - Low byte bit one reads zero
// R3 - Low byte bit zero flags over-range
// R4 - High byte holds result bits thirteen-six
// R5 - Limit register read-only, six comparator flags
// R6 - Flag set when its limit exceeded
// R7 - Limit register top two bits zero
// R8 - Host writes zero to reserved bits
// R9 - Format bit: two's complement or binary
// R10 - Read-back field picks byte order
// R11 - Non-zero mode shifts result automatically
// R12 - Mode zero default, explicit read needed
// R13 - Divider field divides by 1/2/4/8
// R14 - Divided clock drives converter and amplifier
// R15 - Host keeps divided clock within limit
// R16 - Start bit starts; reads busy status
// R17 - Gain codes map to 1..20
// R18 - Channel field selects inputs and configuration
// R19 - Direct start updates gain/channel register
// R20 - Top bit single-ended; bit two swaps
// R21 - Start on second divided falling edge
// R22 - Reset clears every register bit
// R23 - Over-range set when any limit flag
`timescale 1ns/1ns
`default_nettype none

module adc_result_and_control_regs
   import adc_regs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   input  wire logic [2:0]  regAddr,
   input  wire logic [7:0]  regWData,
   input  wire logic        directStart,
   input  wire logic [7:0]  directByte,
   input  wire logic        conversionClockIn,
   input  wire logic        convDone,
   input  wire logic [13:0] convResult,
   input  wire logic [5:0]  limitFlags,
   output logic [7:0]       regRData,
   output logic             dividedConversionClock,
   output logic             convStart,
   output conv_setup_t      convSetup,
   output readback_t        autoReadback
);

   // Stored control state
   logic        straightBinarySelect_q; // Output format select
   logic [1:0]  readbackMode_q;         // Automatic read-back mode
   logic [1:0]  clockDivideSelect_q;    // Conversion clock divider
   logic [2:0]  amplifierGainCode_q;    // Gain code
   logic [3:0]  channelSelect_q;        // Channel select
   logic        convertBusy_q;          // Conversion requested or running
   logic [1:0]  pendFalls_q;            // Falls left before start
   logic [13:0] resultBits_q;           // Formatted result
   logic [5:0]  limitFlags_q;           // Captured comparator flags
   logic        rangeFaultFlag_q;       // Over-range flag
   logic        fallPulse;              // Divided clock falling edge
   logic        startReq;               // Start request this cycle
   logic [13:0] formattedResult;        // Result after format select
   logic [7:0]  resultLowByte;          // Assembled low byte
   logic [7:0]  resultHighByte;         // Assembled high byte
   logic [7:0]  readMux;                // Read data before register

   // Gain code to V/V
   function automatic logic [4:0] gain_factor(input logic [2:0] code);
      case (code)
         3'h0:    gain_factor = 5'h01;
         3'h1:    gain_factor = 5'h02;
         3'h2:    gain_factor = 5'h04;
         3'h3:    gain_factor = 5'h05;
         3'h4:    gain_factor = 5'h08;
         3'h5:    gain_factor = 5'h0a;
         3'h6:    gain_factor = 5'h10;
         3'h7:    gain_factor = 5'h14;
         default: gain_factor = 5'h01;
      endcase
   endfunction : gain_factor

   // Three-bit index to one-hot input line
   function automatic logic [7:0] one_hot(input logic [2:0] idx);
      one_hot = 8'h01 << idx;
   endfunction : one_hot

   // Conversion clock divider, its output paces the analog side
   conv_clock_divider u_divider (
      .clk          (clk),
      .arst_n       (arst_n),
      .clockIn      (conversionClockIn),
      .divideSel    (clockDivideSelect_q),
      .dividedClock (dividedConversionClock), // R14
      .fallPulse    (fallPulse)
   );

   // A start comes from the busy bit of a write or the direct byte
   assign startReq = ((regWrite && regAddr == ADDR_GAIN_CHAN && regWData[GC_BUSY_BIT])
                      || (directStart && directByte[GC_BUSY_BIT])) && !convertBusy_q;

   // Converter control register; reserved bits are not stored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         straightBinarySelect_q <= 1'b0;         // R22
         readbackMode_q         <= RBM_EXPLICIT; // R12
         clockDivideSelect_q    <= 2'h0;
      end else if (regWrite && regAddr == ADDR_CONTROL) begin
         straightBinarySelect_q <= regWData[CTRL_BINARY_BIT];          // R9
         readbackMode_q         <= regWData[CTRL_RBM_HI:CTRL_RBM_LO];  // R10
         clockDivideSelect_q    <= regWData[CTRL_CFD_HI:CTRL_CFD_LO];  // R13
      end
   end

   // Gain/channel register, loaded by writes and by direct starts
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         amplifierGainCode_q <= 3'h0;
         channelSelect_q     <= 4'h0;
      end else if (directStart) begin
         amplifierGainCode_q <= directByte[GC_GAIN_HI:GC_GAIN_LO]; // R19
         channelSelect_q     <= directByte[GC_CHAN_HI:GC_CHAN_LO];
      end else if (regWrite && regAddr == ADDR_GAIN_CHAN) begin
         amplifierGainCode_q <= regWData[GC_GAIN_HI:GC_GAIN_LO]; // R17
         channelSelect_q     <= regWData[GC_CHAN_HI:GC_CHAN_LO]; // R18
      end
   end

   // Start sequencing: count divided falls, then run until done
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         convertBusy_q <= 1'b0;
         pendFalls_q   <= 2'h0;
         convStart     <= 1'b0;
      end else begin
         convStart <= 1'b0;
         if (startReq) begin
            convertBusy_q <= 1'b1; // R16
            pendFalls_q   <= START_FALLS;
         end else if (pendFalls_q != 2'h0) begin
            if (fallPulse) begin
               pendFalls_q <= pendFalls_q - 2'h1;
               convStart   <= (pendFalls_q == 2'h1); // R21
            end
         end else if (convDone && convertBusy_q) begin
            convertBusy_q <= 1'b0; // R16
         end
      end
   end

   // Format select flips the sign bit for straight binary
   assign formattedResult = {convResult[RESULT_MSB] ^ straightBinarySelect_q,
                             convResult[RESULT_MSB-1:0]}; // R9

   // Capture result and comparator flags at the end of a conversion
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         resultBits_q     <= RESULT_RESET;
         limitFlags_q     <= LIMIT_RESET;
         rangeFaultFlag_q <= 1'b0;
      end else if (convDone && convertBusy_q && pendFalls_q == 2'h0) begin
         resultBits_q     <= formattedResult;
         limitFlags_q     <= limitFlags;     // R6
         rangeFaultFlag_q <= |limitFlags;    // R23
      end
   end

   // Byte layouts of the two result registers
   assign resultLowByte  = {resultBits_q[5:0], 1'b0, rangeFaultFlag_q}; // R1 R2 R3
   assign resultHighByte = resultBits_q[RESULT_MSB:6];                  // R4

   // Read decode; unmapped addresses read zero
   always_comb begin
      case (regAddr)
         ADDR_RESULT_LOW:  readMux = resultLowByte;
         ADDR_RESULT_HIGH: readMux = resultHighByte;
         ADDR_LIMIT_FLAGS: readMux = {2'h0, limitFlags_q}; // R5 R7
         ADDR_CONTROL:     readMux = {2'h0, straightBinarySelect_q, 1'b0,
                                      readbackMode_q, clockDivideSelect_q};
         ADDR_GAIN_CHAN:   readMux = {convertBusy_q, amplifierGainCode_q,
                                      channelSelect_q}; // R16
         default:          readMux = BYTE_RESET;
      endcase
   end

   // Registered read data, held between reads
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         regRData <= BYTE_RESET;
      end else if (regRead) begin
         regRData <= readMux;
      end
   end

   // Amplifier and multiplexer setup
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         convSetup <= '0;
      end else begin
         convSetup.gainCode   <= amplifierGainCode_q;
         convSetup.gainFactor <= gain_factor(amplifierGainCode_q); // R17
         if (channelSelect_q[CHAN_SINGLE_BIT]) begin
            convSetup.plusSel  <= one_hot(channelSelect_q[2:0]); // R20
            convSetup.minusSel <= 8'h00;
         end else if (channelSelect_q[CHAN_SWAP_BIT]) begin
            convSetup.plusSel  <= one_hot({channelSelect_q[1:0], 1'b1});
            convSetup.minusSel <= one_hot({channelSelect_q[1:0], 1'b0});
         end else begin
            convSetup.plusSel  <= one_hot({channelSelect_q[1:0], 1'b0});
            convSetup.minusSel <= one_hot({channelSelect_q[1:0], 1'b1});
         end
      end
   end

   // Automatic read-back word, built from the incoming result and flags in the capture cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         autoReadback <= '0;
      end else begin
         autoReadback.valid <= convDone && convertBusy_q && pendFalls_q == 2'h0
                               && readbackMode_q != RBM_EXPLICIT; // R11 R12
         autoReadback.twoBytes <= (readbackMode_q != RBM_HIGH_ONLY);
         case (readbackMode_q)
            RBM_LOW_1ST: begin
               autoReadback.firstByte  <= {formattedResult[5:0], 1'b0, |limitFlags};
               autoReadback.secondByte <= formattedResult[RESULT_MSB:6];
            end
            default: begin
               autoReadback.firstByte  <= formattedResult[RESULT_MSB:6]; // R10
               autoReadback.secondByte <= {formattedResult[5:0], 1'b0, |limitFlags};
            end
         endcase
      end
   end

   // Checks
   property p_start_second_fall;
      @(posedge clk) disable iff (!arst_n)
         convStart |-> $past(fallPulse) && $past(pendFalls_q) == 2'h1;
   endproperty
   a_start_second_fall: assert property (p_start_second_fall) // R21
      else $error("conversion start not on second divided fall");

   property p_request_arms;
      @(posedge clk) disable iff (!arst_n)
         startReq |=> convertBusy_q && pendFalls_q == 2'h2 && !convStart;
   endproperty
   a_request_arms: assert property (p_request_arms) // R16
      else $error("start request did not set busy and arm two falls");

   property p_busy_reads;
      @(posedge clk) disable iff (!arst_n)
         regRead && regAddr == ADDR_GAIN_CHAN |=> regRData[7] == $past(convertBusy_q);
   endproperty
   a_busy_reads: assert property (p_busy_reads) // R16
      else $error("busy bit read back wrong");

   property p_low_byte;
      @(posedge clk) disable iff (!arst_n)
         regRead && regAddr == ADDR_RESULT_LOW |=>
            regRData == {$past(resultBits_q[5:0]), 1'b0, $past(rangeFaultFlag_q)};
   endproperty
   a_low_byte: assert property (p_low_byte) // R1
      else $error("low result byte layout wrong");

   property p_high_byte;
      @(posedge clk) disable iff (!arst_n)
         regRead && regAddr == ADDR_RESULT_HIGH |=> regRData == $past(resultBits_q[13:6]);
   endproperty
   a_high_byte: assert property (p_high_byte) // R4
      else $error("high result byte layout wrong");

   property p_limit_top_zero;
      @(posedge clk) disable iff (!arst_n)
         $past(regRead) && $past(regAddr) == ADDR_LIMIT_FLAGS |-> regRData[7:6] == 2'h0;
   endproperty
   a_limit_top_zero: assert property (p_limit_top_zero) // R7
      else $error("limit register top bits not zero");

   property p_range_fault;
      @(posedge clk) disable iff (!arst_n)
         convDone && convertBusy_q && pendFalls_q == 2'h0 |=>
            rangeFaultFlag_q == ($past(limitFlags) != 6'h00);
   endproperty
   a_range_fault: assert property (p_range_fault) // R23
      else $error("over-range flag disagrees with limit flags");

   property p_format;
      @(posedge clk) disable iff (!arst_n)
         convDone && convertBusy_q && pendFalls_q == 2'h0 |=>
            resultBits_q[13] == ($past(convResult[13]) ^ $past(straightBinarySelect_q));
   endproperty
   a_format: assert property (p_format) // R9
      else $error("result format select not applied");

   property p_auto_mode;
      @(posedge clk) disable iff (!arst_n)
         autoReadback.valid |-> $past(readbackMode_q) != RBM_EXPLICIT;
   endproperty
   a_auto_mode: assert property (p_auto_mode) // R11
      else $error("automatic read-back in explicit mode");

   property p_direct_load;
      @(posedge clk) disable iff (!arst_n)
         directStart |=> channelSelect_q == $past(directByte[3:0])
                         && amplifierGainCode_q == $past(directByte[6:4]);
   endproperty
   a_direct_load: assert property (p_direct_load) // R19
      else $error("direct start did not load gain/channel");

   property p_low_bit_zero;
      @(posedge clk) disable iff (!arst_n)
         regRead && regAddr == ADDR_RESULT_LOW |=> regRData[1] == 1'b0;
   endproperty
   a_low_bit_zero: assert property (p_low_bit_zero) // R2
      else $error("unused low byte bit not zero");

   property p_limit_capture;
      @(posedge clk) disable iff (!arst_n)
         convDone && convertBusy_q && pendFalls_q == 2'h0 |=>
            limitFlags_q == $past(limitFlags);
   endproperty
   a_limit_capture: assert property (p_limit_capture) // R6
      else $error("limit flags not captured at conversion end");

   property p_busy_clears;
      @(posedge clk) disable iff (!arst_n)
         convDone && convertBusy_q && pendFalls_q == 2'h0 |=> !convertBusy_q;
   endproperty
   a_busy_clears: assert property (p_busy_clears) // R16
      else $error("busy not cleared at conversion end");

   property p_explicit_quiet;
      @(posedge clk) disable iff (!arst_n)
         readbackMode_q == RBM_EXPLICIT |=> !autoReadback.valid;
   endproperty
   a_explicit_quiet: assert property (p_explicit_quiet) // R12
      else $error("automatic read-back fired in explicit mode");

   property p_single_ended;
      @(posedge clk) disable iff (!arst_n)
         channelSelect_q[CHAN_SINGLE_BIT] |=> convSetup.minusSel == 8'h00;
   endproperty
   a_single_ended: assert property (p_single_ended) // R20
      else $error("single-ended minus input not grounded");

endmodule : adc_result_and_control_regs
`default_nettype wire

// ---- adc_result_and_control_regs_test.sv ----
`timescale 1ns/1ns
`default_nettype none

module adc_result_and_control_regs_test
   import adc_regs_pkg::*;
;
   logic        clk = 1'b0;          // 20 MHz clock
   logic        arst_n, regWrite, regRead, directStart, conversionClockIn;
   logic        convStart, convDone, dividedConversionClock;
   logic [2:0]  regAddr;             // Register index
   logic [7:0]  regWData, directByte, regRData, ps, ms;
   logic [13:0] convResult, nextResult;
   logic [5:0]  limitFlags, nextFlags;
   conv_setup_t convSetup;           // Analog setup, checked by the test, not fed to the converter model
   readback_t   autoReadback, rbWord;
   logic [4:0]  gainTab [8] = '{5'h01, 5'h02, 5'h04, 5'h05, 5'h08, 5'h0a, 5'h10, 5'h14};
   int          miscompares = 0, n_tests = 0, rbSeen = 0, startCnt = 0;
   int          fallCnt = 0, riseCnt = 0, a, c, d, r0, diff;

   always #25 clk = ~clk;
   // Input conversion clock at 2.5 MHz, so even divide-by-one stays in range
   always #200 conversionClockIn = ~conversionClockIn;

   // Event counters for starts, read-back words and divided clock edges
   always @(posedge clk) begin
      if (convStart === 1'b1) startCnt++;
      if (autoReadback.valid === 1'b1) begin
         rbSeen++;
         rbWord = autoReadback;
      end
   end
   always @(negedge dividedConversionClock) fallCnt++;
   always @(posedge dividedConversionClock) riseCnt++;

   adc_result_and_control_regs u_adc_result_and_control_regs (
      .clk(clk), .arst_n(arst_n), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWData(regWData), .directStart(directStart),
      .directByte(directByte), .conversionClockIn(conversionClockIn),
      .convDone(convDone), .convResult(convResult), .limitFlags(limitFlags),
      .regRData(regRData), .dividedConversionClock(dividedConversionClock),
      .convStart(convStart), .convSetup(convSetup), .autoReadback(autoReadback));

   analog_conv_model u_analog_conv_model (
      .clk(clk), .arst_n(arst_n), .convStart(convStart),
      .divClock(dividedConversionClock), .nextResult(nextResult),
      .nextFlags(nextFlags), .convDone(convDone), .convResult(convResult),
      .limitFlags(limitFlags));

   // Compare and count
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One-cycle write strobe
   task automatic wr(input logic [2:0] adr, input logic [7:0] dat);
      @(negedge clk);
      regWrite = 1'b1;
      regAddr  = adr;
      regWData = dat;
      @(negedge clk);
      regWrite = 1'b0;
   endtask : wr

   // One-cycle read strobe, data settled one cycle later
   task automatic rd(input logic [2:0] adr, input logic [7:0] exp, input string what);
      @(negedge clk);
      regRead = 1'b1;
      regAddr = adr;
      @(negedge clk);
      regRead = 1'b0;
      chk(what, {16'h0000, exp}, {16'h0000, regRData});
   endtask : rd

   // Full conversion by register write or direct command
   task automatic conv(input logic [7:0] ctrl, input logic [7:0] cmd, input logic [13:0] r,
                       input logic [5:0] f, input bit direct);
      logic [7:0] hi, lo;
      int         f0, s0, b0, i;
      hi = {r[13] ^ ctrl[5], r[12:6]};
      lo = {r[5:0], 1'b0, |f};
      wr(ADDR_CONTROL, ctrl);
      nextResult = r;
      nextFlags  = f;
      s0 = startCnt;
      b0 = rbSeen;
      @(negedge clk);
      f0 = fallCnt;
      if (direct) begin
         directStart = 1'b1;
         directByte  = cmd;
      end else begin
         regWrite = 1'b1;
         regAddr  = ADDR_GAIN_CHAN;
         regWData = cmd;
      end
      @(negedge clk);
      directStart = 1'b0;
      regWrite    = 1'b0;
      for (i = 0; i < 200 && startCnt == s0; i++) @(negedge clk);
      chk("start falls", 24'h1, {23'h0, (fallCnt - f0 >= 2) && (fallCnt - f0 <= 3)});
      rd(ADDR_GAIN_CHAN, {1'b1, cmd[6:0]}, "busy");
      wr(ADDR_GAIN_CHAN, cmd);
      for (i = 0; i < 400 && convDone !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      rd(ADDR_RESULT_HIGH, hi, "result high");
      rd(ADDR_RESULT_LOW, lo, "result low");
      rd(ADDR_LIMIT_FLAGS, {2'b00, f}, "limit flags");
      rd(ADDR_GAIN_CHAN, {1'b0, cmd[6:0]}, "idle");
      repeat (20) @(negedge clk);
      chk("start count", 24'(s0 + 1), 24'(startCnt));
      if (ctrl[3:2] == RBM_EXPLICIT) begin
         chk("no readback", 24'(b0), 24'(rbSeen));
      end else begin
         chk("readback count", 24'(b0 + 1), 24'(rbSeen));
         chk("readback word",
             ctrl[3:2] == RBM_LOW_1ST ? {7'h0, 1'b1, lo, hi} :
             ctrl[3:2] == RBM_HIGH_1ST ? {7'h0, 1'b1, hi, lo} : {7'h0, 1'b0, hi, 8'h00},
             {7'h0, rbWord.twoBytes, rbWord.firstByte,
              ctrl[3:2] == RBM_HIGH_ONLY ? 8'h00 : rbWord.secondByte});
      end
   endtask : conv

   // Counts and verdict
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      arst_n = 1'b0;
      regWrite = 1'b0;
      regRead = 1'b0;
      directStart = 1'b0;
      conversionClockIn = 1'b0;
      regAddr = 3'h0;
      regWData = 8'h00;
      directByte = 8'h00;
      nextResult = 14'h0000;
      nextFlags = 6'h00;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      for (a = 0; a < 5; a++) rd(a[2:0], 8'h00, "reset value");
      rd(3'h5, 8'h00, "unmapped");
      wr(ADDR_RESULT_LOW, 8'hff);
      wr(ADDR_LIMIT_FLAGS, 8'hff);
      wr(3'h7, 8'hff);
      rd(ADDR_RESULT_LOW, 8'h00, "read-only low");
      rd(ADDR_LIMIT_FLAGS, 8'h00, "read-only limit");
      wr(ADDR_CONTROL, 8'h2f);
      rd(ADDR_CONTROL, 8'h2f, "control");
      // Every divide code against the input edge count
      for (d = 0; d < 4; d++) begin
         wr(ADDR_CONTROL, {6'h00, d[1:0]});
         repeat (40) @(negedge clk);
         r0 = riseCnt;
         repeat (400) @(negedge clk);
         diff = riseCnt - r0;
         chk("divided rises", 24'h1, {23'h0, diff >= (50 >> d) - 1 && diff <= (50 >> d) + 1});
      end
      // Every channel code, gain codes swept alongside
      for (c = 0; c < 16; c++) begin
         wr(ADDR_GAIN_CHAN, {1'b0, c[2:0], c[3:0]});
         repeat (3) @(negedge clk);
         if (c[3]) begin
            ps = 8'h01 << c[2:0];
            ms = 8'h00;
         end else begin
            ps = 8'h01 << {c[1:0], 1'b0};
            ms = 8'h01 << {c[1:0], 1'b1};
            if (c[2]) {ps, ms} = {ms, ps};
         end
         chk("setup", {c[2:0], gainTab[c[2:0]], ps, ms}, convSetup);
      end
      conv(8'h04, 8'h8a, 14'h2a5d, 6'h00, 1'b0);
      conv(8'h28, 8'hf5, 14'h1234, 6'h21, 1'b0);
      conv(8'h0d, 8'hc3, 14'h3fc1, 6'h3f, 1'b1);
      conv(8'h01, 8'h9c, 14'h0155, 6'h12, 1'b1);
      // Reset in mid-run clears registers that now hold non-zero values
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      rd(ADDR_CONTROL, 8'h00, "reset control");
      rd(ADDR_GAIN_CHAN, 8'h00, "reset gain/channel");
      rd(ADDR_RESULT_HIGH, 8'h00, "reset result high");
      wrap_up();
   end

   // Watchdog against a hang
   initial begin
      #3000000;
      miscompares++;
      wrap_up();
   end
endmodule : adc_result_and_control_regs_test

`default_nettype wire

// ---- analog_conv_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module analog_conv_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        convStart,
   input  wire logic        divClock,
   input  wire logic [13:0] nextResult,
   input  wire logic [5:0]  nextFlags,
   output logic             convDone,
   output logic [13:0]      convResult,
   output logic [5:0]       limitFlags
);
   logic       prevDiv;   // Divided clock one cycle ago
   logic [1:0] falls;     // Divided clock falls seen in this conversion
   logic       running;   // Conversion in progress

   // Converter paced only by the divided clock, done after four falls
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prevDiv    <= 1'b0;
         falls      <= 2'h0;
         running    <= 1'b0;
         convDone   <= 1'b0;
         convResult <= 14'h0000;
         limitFlags <= 6'h00;
      end else begin
         prevDiv    <= divClock;
         convDone   <= 1'b0;
         // Outputs are meaningless outside the done pulse, so keep them moving
         convResult <= ~convResult;
         limitFlags <= ~limitFlags;
         if (convStart) begin
            running <= 1'b1;
            falls   <= 2'h0;
         end else if (running && prevDiv && !divClock) begin
            falls <= falls + 2'h1;
            if (falls == 2'h3) begin
               running    <= 1'b0;
               convDone   <= 1'b1;
               convResult <= nextResult;
               limitFlags <= nextFlags;
            end
         end
      end
   end
endmodule : analog_conv_model

`default_nettype wire

// ---- conv_clock_divider.sv ----
`timescale 1ns/1ns
`default_nettype none

module conv_clock_divider
   import adc_regs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       clockIn,
   input  wire logic [1:0] divideSel,
   output logic            dividedClock,
   output logic            fallPulse
);

   logic       inPrev_q;   // Previous sample of the input clock
   logic [2:0] cnt_q;      // Counts input rising edges
   logic       dividedD;   // Next divided level

   // Edge history and ripple count of the input clock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inPrev_q <= 1'b0;
         cnt_q    <= 3'h0;
      end else begin
         inPrev_q <= clockIn;
         if (clockIn && !inPrev_q) begin
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

   // Divide by 1, 2, 4 or 8
   always_comb begin
      case (divideSel)
         2'h0:    dividedD = clockIn; // R13
         2'h1:    dividedD = cnt_q[0];
         2'h2:    dividedD = cnt_q[1];
         2'h3:    dividedD = cnt_q[2];
         default: dividedD = 1'b0;
      endcase
   end

   // Registered divided clock and its falling-edge pulse
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dividedClock <= 1'b0;
         fallPulse    <= 1'b0;
      end else begin
         dividedClock <= dividedD;
         fallPulse    <= dividedClock & ~dividedD;
      end
   end

endmodule : conv_clock_divider
`default_nettype wire
